// *** inc/bpmu_defines.svh ***
`ifndef BPMU_DEFINES_SVH
`define BPMU_DEFINES_SVH
`define BPMU_NUM_BP 4
`define BPMU_OFS_ADDR0 8'h00
`define BPMU_OFS_ADDR1 8'h04
`define BPMU_OFS_ADDR2 8'h08
`define BPMU_OFS_ADDR3 8'h0C
`define BPMU_OFS_CTRL 8'h10
`define BPMU_OFS_STAT 8'h14
`define BPMU_OFS_CFG 8'h18
`define BPMU_CTRL_GD 13
`define BPMU_CTRL_ONE 10
`define BPMU_CTRL_RST 32'h0000_0400
`define BPMU_CTRL_RW_LSB 16
`define BPMU_CTRL_LEN_LSB 18
`define BPMU_STAT_BD 13
`define BPMU_STAT_BS 14
`define BPMU_STAT_BT 15
`define BPMU_STAT_RST 32'h0000_0000
`define BPMU_CFG_DE 0
`define BPMU_CFG_LM 1
`define BPMU_CFG_RST 2'h0
`define BPMU_RW_INSN 2'h0
`define BPMU_RW_WR 2'h1
`define BPMU_RW_IO 2'h2
`define BPMU_RW_RDWR 2'h3
`define BPMU_LEN_1 2'h0
`define BPMU_LEN_2 2'h1
`define BPMU_LEN_8 2'h2
`define BPMU_LEN_4 2'h3
`define BPMU_VECTOR 8'h01
`endif

// *** inc/bpmu_pkg.sv ***
package bpmu_pkg;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [3:0] size;
    logic is_write;
    logic is_io;
  } bpmu_access_t;

  typedef enum logic [1:0] {
    BPMU_IDLE = 2'h1,
    BPMU_DEFER = 2'h2
  } bpmu_fsm_t;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] status;
    logic [1:0] cfg;
    logic [3:0] pend_hits;
    logic [3:0] defer_hits;
    logic defer_gd;
    bpmu_fsm_t fsm;
    logic exc;
    logic exc_pre;
    logic [3:0] hits;
    logic [7:0] vector;
    logic [31:0] rdata;
  } bpmu_state_t;

endpackage

// *** rtl/bpmu_addr_mem.sv ***
`timescale 1ns/1ps
`include "bpmu_defines.svh"

module bpmu_addr_mem (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic wr_in,
  input wire logic [1:0] wr_idx_in,
  input wire logic [31:0] wr_data_in,
  output logic [`BPMU_NUM_BP*32-1:0] words_out
);

  logic [`BPMU_NUM_BP*32-1:0] mem_ff;
  logic [`BPMU_NUM_BP*32-1:0] nxt_mem;

  // breakpoint address storage, all words visible for parallel compare
  always_comb begin
    nxt_mem = mem_ff;
    if (wr_in) begin
      nxt_mem[wr_idx_in*32 +: 32] = wr_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      mem_ff <= '0;
    end else begin
      mem_ff <= nxt_mem;
    end
  end

  assign words_out = mem_ff;

endmodule

// *** rtl/bpmu_bp_cmp.sv ***
`timescale 1ns/1ps
`include "bpmu_defines.svh"

module bpmu_bp_cmp (
  input wire logic [31:0] base_in,
  input wire logic [1:0] rw_in,
  input wire logic [1:0] len_in,
  input wire logic de_in,
  input wire logic lm_in,
  input wire logic insn_in,
  input wire bpmu_pkg::bpmu_access_t acc_in,
  output logic hit_out
);

  function automatic logic [31:0] span_mask(input logic [1:0] len);
    unique case (len)
      `BPMU_LEN_1: span_mask = 32'h0000_0000;
      `BPMU_LEN_2: span_mask = 32'h0000_0001;
      `BPMU_LEN_4: span_mask = 32'h0000_0003;
      `BPMU_LEN_8: span_mask = 32'h0000_0007;
    endcase
  endfunction

  logic type_ok;
  logic len_ok;
  logic [31:0] mask;
  logic [32:0] lo;
  logic [32:0] hi;
  logic [32:0] acc_lo;
  logic [32:0] acc_hi;

  always_comb begin
    // undefined encodings are treated as never matching
    if (insn_in) begin
      type_ok = (rw_in == `BPMU_RW_INSN);
    end else if (acc_in.is_io) begin
      type_ok = (rw_in == `BPMU_RW_IO) && de_in;
    end else begin
      type_ok = (rw_in == `BPMU_RW_RDWR) ||
                ((rw_in == `BPMU_RW_WR) && acc_in.is_write);
    end
    len_ok = (len_in != `BPMU_LEN_8) || lm_in;
    mask = span_mask(len_in);
    lo = {1'b0, base_in & ~mask};
    hi = lo | {1'b0, mask};
    acc_lo = {1'b0, acc_in.addr};
    acc_hi = acc_lo + {29'h0, acc_in.size} - 33'h1;
    hit_out = acc_in.valid && type_ok && len_ok &&
              (acc_in.size != 4'h0) &&
              (acc_lo <= hi) && (acc_hi >= lo);
  end

endmodule

// *** rtl/bpmu_match_unit.sv ***
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "bpmu_defines.svh"

module bpmu_match_unit (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic ifetch_valid_in,
  input wire logic [31:0] ifetch_addr_in,
  input wire logic ifetch_dr_access_in,
  input wire bpmu_pkg::bpmu_access_t data_acc_in,
  input wire logic retire_in,
  input wire logic rep_iter_in,
  input wire logic single_step_in,
  input wire logic task_trap_in,
  input wire logic task_switch_in,
  output logic dbg_exc_out,
  output logic dbg_exc_pre_out,
  output logic [7:0] dbg_vector_out,
  output logic [3:0] dbg_hits_out
);

  bpmu_pkg::bpmu_state_t state_ff;
  bpmu_pkg::bpmu_state_t nxt_state;

  logic [`BPMU_NUM_BP*32-1:0] bp_words;
  logic [3:0] insn_match;
  logic [3:0] data_match;
  logic [3:0] armed;
  logic addr_wr;
  bpmu_pkg::bpmu_access_t fetch_acc;

  function automatic logic [1:0] ctrl_rw(input logic [31:0] c,
                                         input int n);
    ctrl_rw = c[`BPMU_CTRL_RW_LSB + 4*n +: 2];
  endfunction

  function automatic logic [1:0] ctrl_len(input logic [31:0] c,
                                          input int n);
    ctrl_len = c[`BPMU_CTRL_LEN_LSB + 4*n +: 2];
  endfunction

  function automatic logic is_addr_ofs(input logic [7:0] a);
    is_addr_ofs = (a == `BPMU_OFS_ADDR0) || (a == `BPMU_OFS_ADDR1) ||
                  (a == `BPMU_OFS_ADDR2) || (a == `BPMU_OFS_ADDR3);
  endfunction

  assign addr_wr = reg_wr_in && is_addr_ofs(reg_addr_in);

  bpmu_addr_mem u_mem (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .wr_in(addr_wr),
    .wr_idx_in(reg_addr_in[3:2]),
    .wr_data_in(reg_wdata_in),
    .words_out(bp_words)
  );

  // an instruction fetch is checked as a one-byte access
  always_comb begin
    fetch_acc = '0;
    fetch_acc.valid = ifetch_valid_in;
    fetch_acc.addr = ifetch_addr_in;
    fetch_acc.size = 4'h1;
  end

  genvar gi;
  generate
    for (gi = 0; gi < `BPMU_NUM_BP; gi = gi + 1) begin : g_bp
      // armed by either enable bit
      assign armed[gi] = state_ff.ctrl[2*gi] |
                         state_ff.ctrl[2*gi+1];

      bpmu_bp_cmp u_icmp (
        .base_in(bp_words[gi*32 +: 32]),
        .rw_in(ctrl_rw(state_ff.ctrl, gi)),
        .len_in(ctrl_len(state_ff.ctrl, gi)),
        .de_in(state_ff.cfg[`BPMU_CFG_DE]),
        .lm_in(state_ff.cfg[`BPMU_CFG_LM]),
        .insn_in(1'b1),
        .acc_in(fetch_acc),
        .hit_out(insn_match[gi])
      );

      bpmu_bp_cmp u_dcmp (
        .base_in(bp_words[gi*32 +: 32]),
        .rw_in(ctrl_rw(state_ff.ctrl, gi)),
        .len_in(ctrl_len(state_ff.ctrl, gi)),
        .de_in(state_ff.cfg[`BPMU_CFG_DE]),
        .lm_in(state_ff.cfg[`BPMU_CFG_LM]),
        .insn_in(1'b0),
        .acc_in(data_acc_in),
        .hit_out(data_match[gi])
      );
    end
  endgenerate

  logic [3:0] insn_hits;
  logic [3:0] data_hits;
  logic [3:0] post_hits;
  logic gd_hit;
  logic pre_req;
  logic post_due;
  logic boundary;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.exc = 1'b0;
    nxt_state.exc_pre = 1'b0;
    nxt_state.hits = 4'h0;
    nxt_state.rdata = 32'h0000_0000;

    // software side; hardware updates below override these
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        `BPMU_OFS_CTRL: nxt_state.ctrl = reg_wdata_in;
        `BPMU_OFS_STAT: nxt_state.status = reg_wdata_in;
        `BPMU_OFS_CFG: nxt_state.cfg = reg_wdata_in[1:0];
        default: nxt_state.ctrl = nxt_state.ctrl;
      endcase
    end
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `BPMU_OFS_ADDR0: nxt_state.rdata = bp_words[0 +: 32];
        `BPMU_OFS_ADDR1: nxt_state.rdata = bp_words[32 +: 32];
        `BPMU_OFS_ADDR2: nxt_state.rdata = bp_words[64 +: 32];
        `BPMU_OFS_ADDR3: nxt_state.rdata = bp_words[96 +: 32];
        `BPMU_OFS_CTRL: begin
          nxt_state.rdata = state_ff.ctrl;
          nxt_state.rdata[`BPMU_CTRL_ONE] = 1'b1;
        end
        `BPMU_OFS_STAT: nxt_state.rdata = state_ff.status;
        `BPMU_OFS_CFG: nxt_state.rdata = {30'h0, state_ff.cfg};
        default: nxt_state.rdata = 32'h0000_0000;
      endcase
    end

    // local enables die with the task; globals are left alone
    if (task_switch_in) begin
      for (int n = 0; n < `BPMU_NUM_BP; n++) begin
        nxt_state.ctrl[2*n] = 1'b0;
      end
    end

    insn_hits = armed & insn_match;
    gd_hit = ifetch_valid_in && ifetch_dr_access_in &&
             state_ff.ctrl[`BPMU_CTRL_GD];
    pre_req = (|insn_hits) || gd_hit;
    data_hits = armed & data_match;
    post_hits = state_ff.pend_hits | data_hits;
    // a repeated instruction may report between iterations
    boundary = retire_in || rep_iter_in;
    post_due = boundary &&
               ((|post_hits) || single_step_in || task_trap_in);

    if (boundary) begin
      nxt_state.pend_hits = 4'h0;
    end else begin
      nxt_state.pend_hits = post_hits;
    end

    unique case (state_ff.fsm)
      bpmu_pkg::BPMU_IDLE: begin
        if (post_due) begin
          // post conditions outrank the pending pre check
          nxt_state.exc = 1'b1;
          nxt_state.hits = post_hits;
          nxt_state.status[3:0] = nxt_state.status[3:0] |
                                  post_hits;
          if (single_step_in) begin
            nxt_state.status[`BPMU_STAT_BS] = 1'b1;
          end
          if (task_trap_in) begin
            nxt_state.status[`BPMU_STAT_BT] = 1'b1;
          end
          if (pre_req) begin
            nxt_state.defer_hits = insn_hits;
            nxt_state.defer_gd = gd_hit;
            nxt_state.fsm = bpmu_pkg::BPMU_DEFER;
          end
        end else if (pre_req) begin
          // taken before the instruction; its data hit comes later
          nxt_state.exc = 1'b1;
          nxt_state.exc_pre = 1'b1;
          nxt_state.hits = insn_hits;
          nxt_state.status[3:0] = nxt_state.status[3:0] |
                                  insn_hits;
          if (gd_hit) begin
            nxt_state.ctrl[`BPMU_CTRL_GD] = 1'b0;
            nxt_state.status[`BPMU_STAT_BD] = 1'b1;
          end
        end
      end
      bpmu_pkg::BPMU_DEFER: begin
        // fetches are ignored here: the core is waiting on the pre check
        if (post_due) begin
          nxt_state.exc = 1'b1;
          nxt_state.hits = post_hits;
          nxt_state.status[3:0] = nxt_state.status[3:0] |
                                  post_hits;
          if (single_step_in) begin
            nxt_state.status[`BPMU_STAT_BS] = 1'b1;
          end
          if (task_trap_in) begin
            nxt_state.status[`BPMU_STAT_BT] = 1'b1;
          end
        end else begin
          nxt_state.exc = 1'b1;
          nxt_state.exc_pre = 1'b1;
          nxt_state.hits = state_ff.defer_hits;
          nxt_state.status[3:0] = nxt_state.status[3:0] |
                                  state_ff.defer_hits;
          if (state_ff.defer_gd) begin
            nxt_state.ctrl[`BPMU_CTRL_GD] = 1'b0;
            nxt_state.status[`BPMU_STAT_BD] = 1'b1;
          end
          nxt_state.defer_hits = 4'h0;
          nxt_state.defer_gd = 1'b0;
          nxt_state.fsm = bpmu_pkg::BPMU_IDLE;
        end
      end
      default: nxt_state.fsm = bpmu_pkg::BPMU_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_ff.ctrl <= `BPMU_CTRL_RST;
      state_ff.status <= `BPMU_STAT_RST;
      state_ff.cfg <= `BPMU_CFG_RST;
      state_ff.pend_hits <= 4'h0;
      state_ff.defer_hits <= 4'h0;
      state_ff.defer_gd <= 1'b0;
      state_ff.fsm <= bpmu_pkg::BPMU_IDLE;
      state_ff.exc <= 1'b0;
      state_ff.exc_pre <= 1'b0;
      state_ff.hits <= 4'h0;
      state_ff.vector <= `BPMU_VECTOR;
      state_ff.rdata <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign reg_rdata_out = state_ff.rdata;
  assign dbg_exc_out = state_ff.exc;
  assign dbg_exc_pre_out = state_ff.exc_pre;
  assign dbg_vector_out = state_ff.vector;
  assign dbg_hits_out = state_ff.hits;

endmodule

// *** testbench/bpmu_match_unit_sva.sv ***
`timescale 1ns/1ps
module bpmu_match_unit_sva (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic ifetch_valid_in,
  input wire logic retire_in,
  input wire logic rep_iter_in,
  input wire logic single_step_in,
  input wire logic task_trap_in,
  input wire logic task_switch_in,
  input wire logic dbg_exc_out,
  input wire logic dbg_exc_pre_out,
  input wire logic [7:0] dbg_vector_out,
  input wire logic [3:0] dbg_hits_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  a_vec_const: assert property (
    dbg_vector_out == 8'h01) else $error("vector is not one");
  a_post_timing: assert property (
    dbg_exc_out && !dbg_exc_pre_out |-> $past(retire_in || rep_iter_in))
    else $error("post exception without completion");
  a_post_cause: assert property (
    dbg_exc_out && !dbg_exc_pre_out && dbg_hits_out == 4'h0
    |-> $past(single_step_in || task_trap_in))
    else $error("post exception without cause");
  // a deferred pre exception may only trail a post exception
  a_pre_cause: assert property (
    dbg_exc_out && dbg_exc_pre_out |-> $past(ifetch_valid_in || dbg_exc_out))
    else $error("pre exception without fetch");
  a_hits_idle: assert property (
    !dbg_exc_out |-> dbg_hits_out == 4'h0) else $error("stray hits");
  a_rd_idle: assert property (
    !$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
    else $error("read data outside slot");
  a_ctrl_one: assert property (
    $past(reg_rd_in) && $past(reg_addr_in) == 8'h10 |-> reg_rdata_out[10])
    else $error("control bit ten not one");
  a_local_clear: assert property (
    $past(task_switch_in, 3) && !$past(reg_wr_in, 3) && !$past(reg_wr_in, 2)
    && $past(reg_rd_in) && $past(reg_addr_in) == 8'h10
    |-> (reg_rdata_out & 32'h0000_0055) == 32'h0)
    else $error("local enable survived switch");
endmodule

bind bpmu_match_unit bpmu_match_unit_sva chk (.*);

// *** testbench/bpmu_core_model.sv ***
`timescale 1ns/1ps
module bpmu_core_model (
  input wire logic clk_in,
  output logic fv_out,
  output logic [31:0] fa_out,
  output logic dr_out,
  output bpmu_pkg::bpmu_access_t acc_out,
  output logic ret_out,
  output logic rep_out,
  output logic ss_out,
  output logic tt_out,
  output logic ts_out
);
  // two cycles per call, strobes high in the first; idle buses carry the inverse of the last
  // value so a stale address can never pass for a fresh one
  task step(input logic [6:0] f, input logic [31:0] fa,
    input bpmu_pkg::bpmu_access_t a);
    @(posedge clk_in);
    {ts_out, dr_out, fv_out, tt_out, ss_out} <= f[6:2];
    rep_out <= f[1];
    ret_out <= f[0];
    fa_out <= fa;
    acc_out <= a;
    @(posedge clk_in);
    {ts_out, dr_out, fv_out, tt_out, ss_out, rep_out, ret_out} <= 7'h00;
    fa_out <= ~fa;
    acc_out <= {1'b0, ~a[37:0]};
  endtask
  initial begin
    {ts_out, dr_out, fv_out, tt_out, ss_out, rep_out, ret_out} = 7'h00;
    fa_out = 32'h0;
    acc_out = '0;
  end
endmodule

// *** testbench/breakpoint_match_unit_test.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module breakpoint_match_unit_test;
  localparam logic [4:0] no_exc = 5'h1F;
  logic clk_in = 1'b0, sys_rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00, dbg_vector_out;
  logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, fa;
  logic fv, dr, ret, repeat_prefix, ss, tt, ts, dbg_exc_out, dbg_exc_pre_out;
  logic [3:0] dbg_hits_out;
  bpmu_pkg::bpmu_access_t acc_w;
  logic [4:0] q [$];
  int n_errors = 0, n_tests = 0, i;
  logic [31:0] ta [6] = '{32'hEFFB, 32'hEFFE, 32'hEFFE, 32'hF000,
    32'hF001, 32'hF005};
  logic [3:0] ts_sz [6] = '{4'h8, 4'h2, 4'h4, 4'h1, 4'h2, 4'h4};
  logic [4:0] th [6] = '{5'h05, no_exc, 5'h05, 5'h05, 5'h04, 5'h06};

  bpmu_match_unit uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .ifetch_valid_in(fv),
    .ifetch_addr_in(fa), .ifetch_dr_access_in(dr), .data_acc_in(acc_w),
    .retire_in(ret), .rep_iter_in(repeat_prefix), .single_step_in(ss),
    .task_trap_in(tt), .task_switch_in(ts), .dbg_exc_out(dbg_exc_out),
    .dbg_exc_pre_out(dbg_exc_pre_out), .dbg_vector_out(dbg_vector_out),
    .dbg_hits_out(dbg_hits_out));
  bpmu_core_model m (.clk_in(clk_in), .fv_out(fv), .fa_out(fa),
    .dr_out(dr), .acc_out(acc_w), .ret_out(ret), .rep_out(repeat_prefix),
    .ss_out(ss), .tt_out(tt), .ts_out(ts));

  initial begin
    forever #25 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (dbg_exc_out === 1'b1) begin
      q.push_back({dbg_exc_pre_out, dbg_hits_out});
    end
  end

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1;
    `CHK(reg_rdata_out, e)
  endtask
  // pops one logged exception as {pre, hits}; an empty log reads no_exc
  task ex(input logic [4:0] e);
    logic [4:0] g;
    repeat (3) @(posedge clk_in);
    #1;
    g = q.size() > 0 ? q.pop_front() : no_exc;
    `CHK(g, e)
  endtask
  function automatic bpmu_pkg::bpmu_access_t acc(input logic [31:0] a,
    input logic [3:0] s, input logic w, input logic io);
    acc = {1'b1, a, s, w, io};
  endfunction
  task dx(input logic [31:0] a, input logic [3:0] s, input logic w,
    input logic io, input logic [6:0] f, input logic [4:0] e);
    m.step(7'h00, 32'h0, acc(a, s, w, io));
    m.step(f, 32'h0, '0);
    ex(e);
  endtask
  task wrap_up;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rd(8'h10, 32'h0000_0400);
    rd(8'h14, 32'h0);
    rd(8'h18, 32'h0);
    rd(8'h00, 32'h0);
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, 32'h0);
    `CHK(dbg_vector_out, 8'h01)
    wr(8'h00, 32'h0000_1000);
    rd(8'h00, 32'h0000_1000);
    m.step(7'h10, 32'h0000_1000, '0);
    ex(no_exc);
    wr(8'h10, 32'h0000_0402);
    m.step(7'h10, 32'h0000_1000, '0);
    ex(5'h11);
    rd(8'h14, 32'h1);
    m.step(7'h10, 32'h0000_1001, '0);
    ex(no_exc);
    wr(8'h04, 32'h0000_F000);
    wr(8'h10, 32'h0030_040A);
    m.step(7'h10, 32'h0000_1000, '0);
    ex(5'h11);
    dx(32'hF000, 4'h1, 1'b1, 1'b0, 7'h01, 5'h02);
    m.step(7'h00, 32'h0, acc(32'hF000, 4'h1, 1'b0, 1'b0));
    m.step(7'h11, 32'h0000_1000, '0);
    ex(5'h02);
    ex(5'h11);
    ex(no_exc);
    dx(32'hF000, 4'h1, 1'b0, 1'b0, 7'h02, 5'h02);
    wr(8'h14, 32'h0);
    dx(32'h0100, 4'h1, 1'b0, 1'b0, 7'h05, 5'h00);
    rd(8'h14, 32'h0000_4000);
    dx(32'h0100, 4'h1, 1'b0, 1'b0, 7'h09, 5'h00);
    rd(8'h14, 32'h0000_C000);
    wr(8'h10, 32'h0000_0401);
    m.step(7'h10, 32'h0000_1000, '0);
    ex(5'h11);
    m.step(7'h40, 32'h0, '0);
    rd(8'h10, 32'h0000_0400);
    m.step(7'h10, 32'h0000_1000, '0);
    ex(no_exc);
    wr(8'h10, 32'h0000_0403);
    m.step(7'h40, 32'h0, '0);
    rd(8'h10, 32'h0000_0402);
    m.step(7'h10, 32'h0000_1000, '0);
    ex(5'h11);
    wr(8'h10, 32'h0000_2400);
    wr(8'h14, 32'h0);
    m.step(7'h30, 32'h0000_2000, '0);
    ex(5'h10);
    rd(8'h10, 32'h0000_0400);
    rd(8'h14, 32'h0000_2000);
    wr(8'h00, 32'h0000_F000);
    wr(8'h10, 32'h0001_0402);
    dx(32'hF000, 4'h1, 1'b0, 1'b0, 7'h01, no_exc);
    dx(32'hF000, 4'h1, 1'b1, 1'b0, 7'h01, 5'h01);
    wr(8'h10, 32'h0002_0402);
    dx(32'hF000, 4'h1, 1'b0, 1'b1, 7'h01, no_exc);
    wr(8'h18, 32'h1);
    dx(32'hF000, 4'h1, 1'b0, 1'b1, 7'h01, 5'h01);
    wr(8'h04, 32'h0000_F004);
    wr(8'h08, 32'h0000_F000);
    wr(8'h10, 32'h0BF3_042A);
    wr(8'h18, 32'h0);
    dx(32'hEFFB, 4'h8, 1'b0, 1'b0, 7'h01, 5'h01);
    wr(8'h18, 32'h2);
    for (i = 0; i < 6; i++) begin
      dx(ta[i], ts_sz[i], i[0], 1'b0, 7'h01, th[i]);
    end
    ex(no_exc);
    // a second reset in mid-run must bring back the reset values
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rd(8'h10, 32'h0000_0400);
    rd(8'h04, 32'h0);
    rd(8'h14, 32'h0);
    rd(8'h18, 32'h0);
    m.step(7'h10, 32'h0000_F000, '0);
    ex(no_exc);
    wrap_up();
  end
endmodule
